// ==== verilog/sbt_tap.sv ====
/*
  Boundary-scan test access port: controller, instruction, bypass,
  identity and boundary registers, with serial out on the falling
  test-clock edge. Test clock and pins are sampled by the system clock,
  which must run well above twice the test-clock rate.
  Assumes the pad ring pulls mode-select and data-in high and turns
  tdo_oe_n into the pin's enable; memory logic reads the ring outputs.
*/
`timescale 1ns/1ps
`default_nettype none

`include "sbt_regs.svh"

module sbt_tap
  import sbt_pkg::*;
#(
  parameter int BSR_LEN = `SBT_BSR_LEN,
  parameter int OE_CELL = `SBT_OE_CELL,
  parameter logic [`SBT_ID_W-1:0] IDCODE = `SBT_IDCODE,
  parameter logic [BSR_LEN-1:0] NC_MASK = '0
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Test pins
  input wire sbt_pins_t pins,
  output sbt_tdo_t tdo_pin,
  // Boundary ring
  input wire logic [BSR_LEN-1:0] ring_in,
  output logic [BSR_LEN-1:0] ring_out,
  output logic test_drive,
  output logic q_bus_hiz,
  // Status
  output sbt_tap_state_t tap_state,
  output sbt_instr_t instr
);

  localparam int IR_W = `SBT_IR_W;
  localparam int ID_W = `SBT_ID_W;

  // ========================================================
  // Parameter checks
  generate
    if (BSR_LEN < 2 || OE_CELL < 0 || OE_CELL >= BSR_LEN) begin : g_bad
      $error("sbt_tap: enable cell outside boundary chain");
    end
  endgenerate

  // ========================================================
  // State
  typedef struct packed {
    logic tck_q;
    sbt_tap_state_t st;
    sbt_instr_t ir;
    logic [IR_W-1:0] ir_sh;
    logic byp;
    logic [ID_W-1:0] id_sh;
    logic [BSR_LEN-1:0] bsr_sh;
    logic [BSR_LEN-1:0] bsr_upd;
    logic tdo;
    logic tdo_oe_n;
  } sbt_tap_st_t;

  // Enable cell set, every other latch clear
  localparam logic [BSR_LEN-1:0] OE_ONE =
    {{(BSR_LEN-1){1'h0}}, 1'h1} << OE_CELL;

  localparam sbt_tap_st_t RST_ST = '{
    tck_q: 1'h0,
    st: SBT_TLR,
    ir: SBT_IDCODE,
    ir_sh: `SBT_IR_CAPTURE,
    byp: `SBT_BYPASS_CAPTURE,
    id_sh: '0,
    bsr_sh: '0,
    bsr_upd: OE_ONE,
    tdo: 1'h0,
    tdo_oe_n: 1'h1
  };

  sbt_tap_st_t r;
  sbt_tap_st_t next_r;

  // ========================================================
  // Functions

  // Standard controller transitions on one rising edge
  function automatic sbt_tap_state_t tap_next(
    input sbt_tap_state_t s,
    input logic tms
  );
    unique case (s)
      SBT_TLR: tap_next = tms ? SBT_TLR : SBT_RTI;
      SBT_RTI: tap_next = tms ? SBT_SELDR : SBT_RTI;
      SBT_SELDR: tap_next = tms ? SBT_SELIR : SBT_CAPDR;
      SBT_CAPDR: tap_next = tms ? SBT_EX1DR : SBT_SHDR;
      SBT_SHDR: tap_next = tms ? SBT_EX1DR : SBT_SHDR;
      SBT_EX1DR: tap_next = tms ? SBT_UPDR : SBT_PDR;
      SBT_PDR: tap_next = tms ? SBT_EX2DR : SBT_PDR;
      SBT_EX2DR: tap_next = tms ? SBT_UPDR : SBT_SHDR;
      SBT_UPDR: tap_next = tms ? SBT_SELDR : SBT_RTI;
      SBT_SELIR: tap_next = tms ? SBT_TLR : SBT_CAPIR;
      SBT_CAPIR: tap_next = tms ? SBT_EX1IR : SBT_SHIR;
      SBT_SHIR: tap_next = tms ? SBT_EX1IR : SBT_SHIR;
      SBT_EX1IR: tap_next = tms ? SBT_UPIR : SBT_PIR;
      SBT_PIR: tap_next = tms ? SBT_EX2IR : SBT_PIR;
      SBT_EX2IR: tap_next = tms ? SBT_UPIR : SBT_SHIR;
      SBT_UPIR: tap_next = tms ? SBT_SELDR : SBT_RTI;
    endcase
  endfunction : tap_next

  // Data path chosen by the current instruction
  function automatic sbt_path_t path_of(input sbt_instr_t i);
    unique case (i)
      SBT_EXTEST,
      SBT_SAMPLE,
      SBT_SAMPLE_Z: path_of = SBT_PATH_BSR;
      SBT_IDCODE: path_of = SBT_PATH_ID;
      // Reserved codes fall back to the shortest path
      SBT_RSVD_3,
      SBT_RSVD_5,
      SBT_RSVD_6,
      SBT_BYPASS: path_of = SBT_PATH_BYP;
    endcase
  endfunction : path_of

  // ========================================================
  // Input synchronisers

  sbt_pins_t syn;
  logic [BSR_LEN-1:0] ring_syn;

  sbt_sync #(
    .W(3),
    .RST_VAL({1'h0, `SBT_TMS_IDLE, `SBT_TDI_IDLE})
  ) u_pin_sync (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .d(pins),
    .q(syn)
  );

  // Ring values come from the fast memory domain
  sbt_sync #(
    .W(BSR_LEN),
    .RST_VAL('0)
  ) u_ring_sync (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .d(ring_in),
    .q(ring_syn)
  );

  // ========================================================
  // Test-clock edge detection

  logic tck_rise;
  logic tck_fall;
  sbt_path_t path;

  // Edges seen only on enabled system clocks
  assign tck_rise = ce && syn.tck && !r.tck_q;
  assign tck_fall = ce && !syn.tck && r.tck_q;
  assign path = path_of(r.ir);

  // ========================================================
  // Next-state logic
  always_comb begin
    next_r = r;
    if (ce) begin
      next_r.tck_q = syn.tck;
    end

    if (tck_rise) begin
      next_r.st = tap_next(r.st, syn.tms);

      if (r.st == SBT_CAPIR) begin
        next_r.ir_sh = `SBT_IR_CAPTURE;
      end

      // in at MSB, out at LSB
      if (r.st == SBT_SHIR) begin
        next_r.ir_sh = {syn.tdi, r.ir_sh[IR_W-1:1]};
      end

      if (r.st == SBT_UPIR) begin
        next_r.ir = sbt_instr_t'(r.ir_sh);
      end

      // Capture into the selected data register
      if (r.st == SBT_CAPDR) begin
        unique case (path)
          SBT_PATH_BSR: next_r.bsr_sh = ring_syn & ~NC_MASK;
          SBT_PATH_ID: next_r.id_sh = IDCODE;
          SBT_PATH_BYP: next_r.byp = `SBT_BYPASS_CAPTURE;
          default: next_r.byp = `SBT_BYPASS_CAPTURE;
        endcase
      end

      if (r.st == SBT_SHDR) begin
        unique case (path)
          SBT_PATH_BSR:
            next_r.bsr_sh = {syn.tdi, r.bsr_sh[BSR_LEN-1:1]};
          SBT_PATH_ID:
            next_r.id_sh = {syn.tdi, r.id_sh[ID_W-1:1]};
          SBT_PATH_BYP: next_r.byp = syn.tdi;
          default: next_r.byp = syn.tdi;
        endcase
      end

      // Preload latches follow the chain at Update-DR
      if (r.st == SBT_UPDR && path == SBT_PATH_BSR) begin
        next_r.bsr_upd = r.bsr_sh;
      end

      if (next_r.st == SBT_TLR) begin
        next_r.ir = SBT_IDCODE;
        next_r.bsr_upd[OE_CELL] = 1'h1;
      end
    end

    // serial out moves on the fall
    if (tck_fall) begin
      next_r.tdo_oe_n = !(r.st == SBT_SHDR || r.st == SBT_SHIR);
      if (r.st == SBT_SHIR) begin
        next_r.tdo = r.ir_sh[0];
      end else begin
        unique case (path)
          SBT_PATH_BSR: next_r.tdo = r.bsr_sh[0];
          SBT_PATH_ID: next_r.tdo = r.id_sh[0];
          SBT_PATH_BYP: next_r.tdo = r.byp;
          default: next_r.tdo = r.byp;
        endcase
      end
    end
  end

  // ========================================================
  // State register
  // power-up leaves serial out undriven
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      r <= RST_ST;
    end else begin
      r <= next_r;
    end
  end

  // ========================================================
  // Outputs

  // Serial out pin straight from flops
  assign tdo_pin = '{tdo: r.tdo,
                     tdo_oe_n: r.tdo_oe_n};

  assign ring_out = r.bsr_upd;
  assign test_drive = (r.ir == SBT_EXTEST);

  // memory only sees ring controls, idle after reset
  assign q_bus_hiz = (r.ir == SBT_SAMPLE_Z) ||
                     (r.ir == SBT_EXTEST && !r.bsr_upd[OE_CELL]);

  // Status for debug
  assign tap_state = r.st;
  assign instr = r.ir;

endmodule : sbt_tap

`default_nettype wire

// ==== shared/sbt_regs.svh ====
/*
  Constants for the boundary-scan test port: widths, cell positions,
  instruction codes, capture patterns, reset values and identity code.
  Assumes inclusion by the package, the design modules and the testbench.
*/
`ifndef SBT_REGS_SVH
`define SBT_REGS_SVH

// ==========================================================
// Register widths
`define SBT_IR_W 3
`define SBT_ID_W 32
`define SBT_BSR_LEN 64

// ==========================================================
// Boundary cell positions
`define SBT_OE_CELL 47

// ==========================================================
// Instruction codes
`define SBT_OP_EXTEST 3'h0
`define SBT_OP_IDCODE 3'h1
`define SBT_OP_SAMPLE_Z 3'h2
`define SBT_OP_RSVD_3 3'h3
`define SBT_OP_SAMPLE 3'h4
`define SBT_OP_RSVD_5 3'h5
`define SBT_OP_RSVD_6 3'h6
`define SBT_OP_BYPASS 3'h7

// ==========================================================
// Capture patterns and reset values
`define SBT_IR_CAPTURE 3'h1
`define SBT_BYPASS_CAPTURE 1'h0
`define SBT_TMS_IDLE 1'h1
`define SBT_TDI_IDLE 1'h1
`define SBT_TLR_CLKS 5

// Identity code: arbitrary value, bit 0 set as scan convention asks
`define SBT_IDCODE 32'h0ABCD0F1

`endif

// ==== shared/sbt_pkg.sv ====
/*
  Types for the boundary-scan test port: controller states,
  instructions, scan paths and the pin carriers.
  Assumes sbt_regs.svh is on the include path.
*/
`include "sbt_regs.svh"

package sbt_pkg;

  // ========================================================
  // Controller states, standard encoding
  typedef enum logic [3:0] {
    SBT_EX2DR = 4'h0,
    SBT_EX1DR = 4'h1,
    SBT_SHDR = 4'h2,
    SBT_PDR = 4'h3,
    SBT_SELIR = 4'h4,
    SBT_UPDR = 4'h5,
    SBT_CAPDR = 4'h6,
    SBT_SELDR = 4'h7,
    SBT_EX2IR = 4'h8,
    SBT_EX1IR = 4'h9,
    SBT_SHIR = 4'hA,
    SBT_PIR = 4'hB,
    SBT_RTI = 4'hC,
    SBT_UPIR = 4'hD,
    SBT_CAPIR = 4'hE,
    SBT_TLR = 4'hF
  } sbt_tap_state_t;

  // ========================================================
  // Instructions, all eight codes named
  typedef enum logic [`SBT_IR_W-1:0] {
    SBT_EXTEST = `SBT_OP_EXTEST,
    SBT_IDCODE = `SBT_OP_IDCODE,
    SBT_SAMPLE_Z = `SBT_OP_SAMPLE_Z,
    SBT_RSVD_3 = `SBT_OP_RSVD_3,
    SBT_SAMPLE = `SBT_OP_SAMPLE,
    SBT_RSVD_5 = `SBT_OP_RSVD_5,
    SBT_RSVD_6 = `SBT_OP_RSVD_6,
    SBT_BYPASS = `SBT_OP_BYPASS
  } sbt_instr_t;

  // ========================================================
  // Scan path between serial in and serial out
  typedef enum logic [1:0] {
    SBT_PATH_BSR = 2'h0,
    SBT_PATH_ID = 2'h1,
    SBT_PATH_BYP = 2'h2
  } sbt_path_t;

  // ========================================================
  // Pin carriers
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } sbt_pins_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe_n;
  } sbt_tdo_t;

endpackage : sbt_pkg

// ==== verilog/sbt_sync.sv ====
/*
  Two-stage level synchroniser with a reset value per instance.
  Assumes the caller reads only q; stage one feeds stage two alone.
*/
`timescale 1ns/1ps
`default_nettype none

module sbt_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ========================================================
  // State
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sbt_sync_st_t;

  sbt_sync_st_t r;
  sbt_sync_st_t next_r;

  // Shift one stage per enabled clock
  always_comb begin
    next_r = r;
    if (ce) begin
      next_r.s1 = d;
      next_r.s2 = r.s1;
    end
  end

  // Register, reset to the instance's RST_VAL
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      r <= {RST_VAL, RST_VAL};
    end else begin
      r <= next_r;
    end
  end

  assign q = r.s2;

endmodule : sbt_sync

`default_nettype wire

// ==== dv/sbt_tap_assertions.sv ====
/*
  Checker for the test port: link timing, controller and decode.
  Assumes tck high and low phases of at least four system clocks.
*/
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Checker
module sbt_tap_assertions
  import sbt_pkg::*;
#(
  parameter int BSR_LEN = 64,
  parameter int OE_CELL = 47
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // Test pins
  input wire sbt_pins_t pins,
  input wire sbt_tdo_t tdo_pin,
  // Ring and status
  input wire logic [BSR_LEN-1:0] ring_in,
  input wire logic [BSR_LEN-1:0] ring_out,
  input wire logic test_drive,
  input wire logic q_bus_hiz,
  input wire sbt_tap_state_t tap_state,
  input wire sbt_instr_t instr
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Count tck rises seen with mode-select high, saturating
  logic tck_q;
  logic [2:0] n_hi;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tck_q <= 1'b0;
      n_hi <= 3'h0;
    end else begin
      tck_q <= pins.tck;
      if (!pins.tms) n_hi <= 3'h0;
      else if (pins.tck && !tck_q && n_hi != 3'h7) n_hi <= n_hi + 3'h1;
    end
  end

  // Serial out driven only around shift states
  property p_oe_shift;
    !tdo_pin.tdo_oe_n |->
      tap_state inside {SBT_SHDR, SBT_SHIR, SBT_EX1DR, SBT_EX1IR};
  endproperty
  a_oe_shift: assert property (p_oe_shift)
    else $error("tdo driven outside shift");

  // Outputs move after falls, state after rises; sync delay is 2-3
  property p_tdo_fall;
    $changed(tdo_pin) |-> !$past(pins.tck, 2);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall)
    else $error("tdo changed while tck high");
  property p_state_rise;
    $changed(tap_state) |-> $past(pins.tck, 2);
  endproperty
  a_state_rise: assert property (p_state_rise)
    else $error("state changed while tck low");

  // Five high rises land in reset state
  property p_tlr5;
    n_hi >= 3'h5 |-> ##4 tap_state == SBT_TLR;
  endproperty
  a_tlr5: assert property (p_tlr5)
    else $error("five high rises missed reset state");
  property p_tlr_vals;
    tap_state == SBT_TLR |-> instr == SBT_IDCODE && ring_out[OE_CELL];
  endproperty
  a_tlr_vals: assert property (p_tlr_vals)
    else $error("reset state values wrong");

  // Instruction and latches change only at update or reset
  property p_instr_upd;
    $changed(instr) |-> $past(tap_state) == SBT_UPIR || tap_state == SBT_TLR;
  endproperty
  a_instr_upd: assert property (p_instr_upd)
    else $error("instruction changed outside update");
  property p_ring_upd;
    $changed(ring_out) |->
      $past(tap_state) == SBT_UPDR || tap_state == SBT_TLR;
  endproperty
  a_ring_upd: assert property (p_ring_upd)
    else $error("ring latches changed outside update");

  // Output bus decode
  property p_drive;
    test_drive == (instr == SBT_EXTEST);
  endproperty
  a_drive: assert property (p_drive)
    else $error("test drive decode wrong");
  property p_hiz;
    q_bus_hiz == (instr == SBT_SAMPLE_Z ||
      instr == SBT_EXTEST && !ring_out[OE_CELL]);
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("bus high-z decode wrong");

  // Main scenarios reached
  c_shdr: cover property (tap_state == SBT_SHDR && !tdo_pin.tdo_oe_n);
  c_upir: cover property (tap_state == SBT_UPIR);
  c_extest: cover property (test_drive && q_bus_hiz);
endmodule : sbt_tap_assertions

bind sbt_tap sbt_tap_assertions #(.BSR_LEN(BSR_LEN), .OE_CELL(OE_CELL))
  u_sbt_tap_assertions (.clock(clock), .rst(rst), .ce(ce), .pins(pins),
  .tdo_pin(tdo_pin), .ring_in(ring_in), .ring_out(ring_out),
  .test_drive(test_drive), .q_bus_hiz(q_bus_hiz),
  .tap_state(tap_state), .instr(instr));

`default_nettype wire

// ==== dv/sbt_ctl_model.sv ====
/*
  Board test controller model: makes tck, drives mode-select and data-in.
  Assumes the bench calls step for every tck period; tck rests low.
*/
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Controller model
module sbt_ctl_model
  import sbt_pkg::*;
(
  // System clock paces the link
  input wire logic clock,
  // Test pins
  output var sbt_pins_t pins,
  input wire sbt_tdo_t tdo_pin
);
  initial pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};

  // one 400 ns period, tdo read before rise
  task automatic step(input logic tms, input logic tdi,
    output logic tdo, output logic oe_n);
    @(posedge clock) #1;
    pins.tms = tms;
    pins.tdi = tdi;
    repeat (3) @(posedge clock);
    #1;
    // Undriven pin reads inverted, so a missing drive shows as bad data
    tdo = tdo_pin.tdo_oe_n ? !tdo_pin.tdo : tdo_pin.tdo;
    oe_n = tdo_pin.tdo_oe_n;
    pins.tck = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    pins.tck = 1'b0;
  endtask : step
endmodule : sbt_ctl_model

`default_nettype wire

// ==== dv/sbt_tap_test.sv ====
/*
  Testbench for the test port: scans through every register path.
  Assumes the controller model and the bound checker are compiled.
*/
`timescale 1ns/1ps
`default_nettype none

`include "sbt_regs.svh"

// ==========================================================
// Bench
module sbt_tap_test
  import sbt_pkg::*;
;
  localparam logic [63:0] NC = 64'hF000_0000_0000_0000;
  localparam logic [63:0] RING = 64'hFEDC_BA98_7654_3210;
  localparam logic [63:0] PRE = 64'hA5A5_5A5A_0000_3C3C;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [63:0] ring_in = RING;
  sbt_pins_t pins;
  sbt_tdo_t tdo_pin;
  logic [63:0] ring_out;
  logic test_drive;
  logic q_bus_hiz;
  sbt_tap_state_t tap_state;
  sbt_instr_t instr;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;

  // Clock and hang guard; full run is about 2600 cycles
  always #25 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // Design and far side
  sbt_tap #(.NC_MASK(NC)) u_sbt_tap (.clock(clock), .rst(rst), .ce(ce),
    .pins(pins), .tdo_pin(tdo_pin), .ring_in(ring_in),
    .ring_out(ring_out), .test_drive(test_drive), .q_bus_hiz(q_bus_hiz),
    .tap_state(tap_state), .instr(instr));
  sbt_ctl_model u_sbt_ctl_model (.clock(clock), .pins(pins),
    .tdo_pin(tdo_pin));

  // ========================================================
  // Shared tasks
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic go(input logic [7:0] seq, input int n);
    logic t;
    logic o;
    for (int i = 0; i < n; i++) u_sbt_ctl_model.step(seq[i], 1'b1, t, o);
  endtask : go

  // Last bit leaves with mode-select high, into Exit1
  task automatic scan(input logic [63:0] din, input int n,
    output logic [63:0] dout);
    logic o;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      u_sbt_ctl_model.step(i == n - 1, din[i], dout[i], o);
      chk(o, 1'b0);
    end
  endtask : scan

  task automatic dr(input logic [63:0] din, output logic [63:0] dout);
    go(8'h01, 3);
    scan(din, 64, dout);
    go(8'h01, 2);
  endtask : dr

  // Only the five defined codes are ever loaded
  task automatic ir(input sbt_instr_t code);
    logic [63:0] cap;
    sbt_instr_t old;
    old = instr;
    go(8'h03, 4);
    scan({61'h0, code}, 3, cap);
    chk(cap, 64'h1);
    chk(instr, old);
    go(8'h01, 2);
    chk(instr, code);
  endtask : ir

  // ========================================================
  // Scenarios
  task automatic t_reset;
    chk(tap_state, SBT_TLR);
    chk(instr, SBT_IDCODE);
    chk(tdo_pin.tdo_oe_n, 1'b1);
    chk(ring_out, 64'h1 << `SBT_OE_CELL);
  endtask : t_reset

  task automatic t_idcode;
    logic [63:0] d;
    go(8'h00, 1);
    dr(64'h1234_5678_9ABC_DEF0, d);
    chk(d, {32'h9ABC_DEF0, `SBT_IDCODE});
  endtask : t_idcode

  task automatic t_bypass;
    logic [63:0] d;
    ir(SBT_BYPASS);
    dr(64'h1234_5678_9ABC_DEF1, d);
    chk(d, 64'h1234_5678_9ABC_DEF1 << 1);
  endtask : t_bypass

  // Preload clears the enable cell, so external test floats the bus
  task automatic t_bsr;
    logic [63:0] d;
    ir(SBT_SAMPLE);
    dr(PRE, d);
    chk(d, RING & ~NC);
    chk(ring_out, PRE);
    ir(SBT_EXTEST);
    chk(test_drive, 1'b1);
    chk(q_bus_hiz, 1'b1);
    // Enable cell set: external test now drives the bus
    dr(PRE | (64'h1 << `SBT_OE_CELL), d);
    chk(d, RING & ~NC);
    chk(ring_out, PRE | (64'h1 << `SBT_OE_CELL));
    chk(q_bus_hiz, 1'b0);
    ir(SBT_SAMPLE_Z);
    chk(test_drive, 1'b0);
    chk(q_bus_hiz, 1'b1);
  endtask : t_bsr

  // From Pause-DR all five high rises are needed
  task automatic t_reset5;
    go(8'h05, 4);
    chk(tap_state, SBT_PDR);
    go(8'h1F, 5);
    // Let the checker's reset-state window close before the end
    repeat (4) @(posedge clock);
    #1;
    chk(tap_state, SBT_TLR);
    chk(instr, SBT_IDCODE);
    chk(ring_out[`SBT_OE_CELL], 1'b1);
    chk(q_bus_hiz, 1'b0);
  endtask : t_reset5

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  // Main sequence
  initial begin
    repeat (6) @(posedge clock);
    #1;
    rst = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    t_reset();
    t_idcode();
    t_bypass();
    t_bsr();
    t_reset5();
    end_sim();
  end
endmodule : sbt_tap_test

`default_nettype wire
